// File: rtl/iao_exec.sv
// module: four-phase execute slice for increment, increment-skip and or-immediate
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// What this block does
// - Register-increment adds one to the addressed file register, wrapping, and updates zero.
// - Destination bit 0 sends the result to the working register, 1 back to the file register.
// - Increment completes in one cycle: decode Q1, read strobe and add Q3, w written at the end of Q4, file write strobe in the next Q1.
// - Increment-and-skip changes no flag; a zero result swaps the next instruction for a nop.
// - Or-immediate ORs the 8-bit literal into w and updates zero, all in one cycle.
// ----------------------------------------------------------------
module iao_exec
    import iao_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    input  wire logic [13:0] i_instr,
    input  wire logic [7:0]  i_freg_rdata,
    output var  iao_freg_t   o_freg,
    output var  logic [7:0]  o_w,
    output var  logic        o_z,
    output var  logic        o_z_wr,
    output var  logic        o_pc_skip,
    output var  logic        o_done,
    output var  iao_phase_t  o_phase
);

    iao_state_t s_q;
    iao_state_t s_d;
    logic [5:0] opc;

    assign opc = i_instr[OPC_TOP:OPC_BOT];

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d          = s_q;
        s_d.freg.rd  = 1'b0;
        s_d.freg.wr  = 1'b0;
        s_d.z_wr     = 1'b0;
        s_d.pc_skip  = 1'b0;
        s_d.done     = 1'b0;
        case (s_q.phase)
            IAO_Q1: begin
                s_d.phase    = IAO_Q2;
                s_d.skip_cyc = s_q.flush;
                s_d.flush    = 1'b0;
                s_d.dest     = i_instr[DEST_BIT];
                s_d.addr     = i_instr[6:0];
                s_d.lit      = i_instr[7:0];
                // flushed slot decodes as nothing: the inserted nop cycle
                if (s_q.flush) begin
                    s_d.op = IAO_OP_NONE;
                end else if (opc == OPC_INC_HI) begin
                    s_d.op = IAO_OP_INC;
                end else if (opc == OPC_INCSZ_HI) begin
                    s_d.op = IAO_OP_INCSZ;
                end else if (opc == OPC_IORL_HI) begin
                    s_d.op = IAO_OP_IORL;
                end else begin
                    s_d.op = IAO_OP_NONE;
                end
            end
            IAO_Q2: begin
                s_d.phase = IAO_Q3;
                if (s_q.op == IAO_OP_INC || s_q.op == IAO_OP_INCSZ) begin
                    s_d.freg.addr = s_q.addr;
                    s_d.freg.rd   = 1'b1;
                end
            end
            IAO_Q3: begin
                s_d.phase = IAO_Q4;
                // read data is taken in the same phase as the read strobe, Q3
                case (s_q.op)
                    IAO_OP_INC,
                    IAO_OP_INCSZ: s_d.res = i_freg_rdata + 8'h01;
                    IAO_OP_IORL:  s_d.res = s_q.w | s_q.lit;
                    default:      s_d.res = s_q.res;
                endcase
            end
            IAO_Q4: begin
                s_d.phase = IAO_Q1;
                s_d.done  = (s_q.op != IAO_OP_NONE);
                if (s_q.op == IAO_OP_INC || s_q.op == IAO_OP_INCSZ) begin
                    if (s_q.dest == DEST_W) begin
                        s_d.w = s_q.res;
                    end else begin
                        s_d.freg.addr  = s_q.addr;
                        s_d.freg.wdata = s_q.res;
                        s_d.freg.wr    = 1'b1;
                    end
                end
                if (s_q.op == IAO_OP_INC || s_q.op == IAO_OP_IORL) begin
                    s_d.z    = (s_q.res == 8'h00);
                    s_d.z_wr = 1'b1;
                end
                if (s_q.op == IAO_OP_IORL) begin
                    s_d.w = s_q.res;
                end
                if (s_q.op == IAO_OP_INCSZ && s_q.res == 8'h00) begin
                    s_d.flush   = 1'b1;
                    s_d.pc_skip = 1'b1;
                end
            end
            default: s_d.phase = IAO_Q1;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_q       <= '0;
            s_q.phase <= IAO_Q1;
            s_q.w     <= W_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_freg    = s_q.freg;
    assign o_w       = s_q.w;
    assign o_z       = s_q.z;
    assign o_z_wr    = s_q.z_wr;
    assign o_pc_skip = s_q.pc_skip;
    assign o_done    = s_q.done;
    assign o_phase   = s_q.phase;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence seq_q4_done;
        s_q.phase == IAO_Q4 && s_q.op != IAO_OP_NONE;
    endsequence

    AST_INC_WRAP: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        s_q.phase == IAO_Q3 && s_q.op == IAO_OP_INC |=> s_q.res == $past(i_freg_rdata) + 8'h01)
        else $error("increment result wrong");
    AST_DEST_W: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        s_q.phase == IAO_Q4 && s_q.op == IAO_OP_INC && s_q.dest == DEST_W
        |=> o_w == $past(s_q.res) && !o_freg.wr)
        else $error("increment to w failed");
    AST_DEST_F: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        s_q.phase == IAO_Q4 && s_q.op == IAO_OP_INC && s_q.dest == DEST_F
        |=> o_freg.wr && o_freg.wdata == $past(s_q.res) && $stable(o_w))
        else $error("increment to file failed");
    AST_ONE_CYCLE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        s_q.phase == IAO_Q1 && !s_q.flush && opc == OPC_INC_HI |-> ##3 seq_q4_done ##1 o_done)
        else $error("increment not done in four phases");
    AST_SKIP_NOFLAG: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        s_q.phase == IAO_Q4 && s_q.op == IAO_OP_INCSZ |=> !o_z_wr && $stable(o_z))
        else $error("skip op touched zero");
    AST_SKIP_NOP: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        s_q.phase == IAO_Q4 && s_q.op == IAO_OP_INCSZ && s_q.res == 8'h00
        |=> o_pc_skip ##1 s_q.op == IAO_OP_NONE && s_q.skip_cyc ##3 !o_done)
        else $error("skip cycle not inserted");
    AST_IORL: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        s_q.phase == IAO_Q1 && !s_q.flush && opc == OPC_IORL_HI
        |-> ##4 o_w == ($past(o_w, 4) | $past(i_instr[7:0], 4)) && o_z_wr)
        else $error("or immediate wrong");
    AST_ZERO: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_z_wr |-> o_z == ($past(s_q.res) == 8'h00))
        else $error("zero flag wrong");

    // ----------------------------------------------------------------
    // phase ring and file port timing
    // ----------------------------------------------------------------
    sequence seq_ring;
        o_phase == IAO_Q2 ##1 o_phase == IAO_Q3 ##1 o_phase == IAO_Q4 ##1 o_phase == IAO_Q1;
    endsequence

    AST_PHASE_RING: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_phase == IAO_Q1 |=> seq_ring)
        else $error("phase ring broken");
    AST_RD_SLOT: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        s_q.phase == IAO_Q2 && (s_q.op == IAO_OP_INC || s_q.op == IAO_OP_INCSZ)
        |=> o_phase == IAO_Q3 && o_freg.rd && o_freg.addr == $past(s_q.addr))
        else $error("file read not issued in q3");
    AST_RD_ONLY_Q3: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_freg.rd |-> o_phase == IAO_Q3)
        else $error("file read outside q3");
    AST_WR_ONLY_Q1: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_freg.wr |-> o_phase == IAO_Q1 && o_freg.addr == s_q.addr)
        else $error("file write misplaced");

    // ----------------------------------------------------------------
    // skip path: result, destination and the swallowed slot
    // ----------------------------------------------------------------
    sequence seq_quiet;
        !o_done && !o_z_wr && !o_freg.wr && !o_pc_skip && $stable(o_w) && $stable(o_z);
    endsequence

    AST_SKIP_RES: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        s_q.phase == IAO_Q3 && s_q.op == IAO_OP_INCSZ
        |=> s_q.res == $past(i_freg_rdata) + 8'h01)
        else $error("skip op result wrong");
    AST_SKIP_DEST_W: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        s_q.phase == IAO_Q4 && s_q.op == IAO_OP_INCSZ && s_q.dest == DEST_W
        |=> o_w == $past(s_q.res) && !o_freg.wr)
        else $error("skip op to w failed");
    AST_SKIP_DEST_F: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        s_q.phase == IAO_Q4 && s_q.op == IAO_OP_INCSZ && s_q.dest == DEST_F
        |=> o_freg.wr && o_freg.wdata == $past(s_q.res) && $stable(o_w))
        else $error("skip op to file failed");
    AST_NO_SKIP: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        s_q.phase == IAO_Q4 && !(s_q.op == IAO_OP_INCSZ && s_q.res == 8'h00)
        |=> !o_pc_skip)
        else $error("skip without zero result");
    AST_PC_SKIP_Q1: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_pc_skip |-> o_phase == IAO_Q1 && s_q.flush)
        else $error("skip pulse misplaced");
    // an empty slot, flushed or undecoded, must leave every output alone
    AST_NOP_QUIET: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        s_q.phase == IAO_Q4 && s_q.op == IAO_OP_NONE |=> seq_quiet)
        else $error("empty slot changed state");

    // ----------------------------------------------------------------
    // or-immediate
    // ----------------------------------------------------------------
    AST_IORL_LIT: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        s_q.phase == IAO_Q1 && !s_q.flush && opc == OPC_IORL_HI
        |=> s_q.lit == $past(i_instr[7:0]))
        else $error("literal not captured");
    AST_IORL_NO_FILE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        s_q.phase == IAO_Q2 && s_q.op == IAO_OP_IORL |=> !o_freg.rd ##2 !o_freg.wr)
        else $error("or immediate touched file");

endmodule
`default_nettype wire

// File: rtl/iao_pkg.sv
// package: constants and types for the increment / or-immediate execute slice
package iao_pkg;

    // ----------------------------------------------------------------
    // opcode patterns
    // ----------------------------------------------------------------
    localparam logic [5:0] OPC_INC_HI   = 6'h0A;  // 00 1010 d fffffff
    localparam logic [5:0] OPC_INCSZ_HI = 6'h0F;  // 00 1111 d fffffff
    localparam logic [5:0] OPC_IORL_HI  = 6'h38;  // 11 1000 kkkkkkkk
    localparam int         OPC_TOP      = 13;
    localparam int         OPC_BOT      = 8;
    localparam int         DEST_BIT     = 7;
    localparam logic       DEST_W       = 1'h0;
    localparam logic       DEST_F       = 1'h1;

    // ----------------------------------------------------------------
    // reset values and timing
    // ----------------------------------------------------------------
    localparam logic [7:0]  W_RST       = 8'h00;
    localparam logic [13:0] INSTR_NOP   = 14'h0000;
    localparam int          PHASES      = 4;

    typedef enum logic [1:0] {
        IAO_Q1 = 2'b00,
        IAO_Q2 = 2'b01,
        IAO_Q3 = 2'b10,
        IAO_Q4 = 2'b11
    } iao_phase_t;

    typedef enum logic [1:0] {
        IAO_OP_NONE  = 2'b00,
        IAO_OP_INC   = 2'b01,
        IAO_OP_INCSZ = 2'b10,
        IAO_OP_IORL  = 2'b11
    } iao_op_t;

    // file register port towards the register file
    typedef struct packed {
        logic [6:0] addr;
        logic       rd;
        logic       wr;
        logic [7:0] wdata;
    } iao_freg_t;

    typedef struct packed {
        iao_phase_t phase;
        iao_op_t    op;
        logic       dest;
        logic [6:0] addr;
        logic [7:0] lit;
        logic [7:0] opnd;
        logic [7:0] res;
        logic       flush;
        logic       skip_cyc;
        logic [7:0] w;
        logic       z;
        logic       z_wr;
        logic       pc_skip;
        logic       done;
        iao_freg_t  freg;
    } iao_state_t;

endpackage

// File: testbench/iao_exec_tb.sv
// testbench: directed scenarios for the increment / or-immediate execute slice
`timescale 1ns/1ps
`default_nettype none
module iao_exec_tb;
    import iao_pkg::*;
    // wdata is ignored where no write is expected, done where no op runs
    localparam logic [20:0] ALL = 21'h1FFFFF;
    localparam logic [20:0] NWD = 21'h1FFC03;
    localparam logic [20:0] NDN = 21'h1FFC02;
    logic        core_clk;
    logic        rst_n;
    logic [13:0] instr;
    logic [7:0]  rdata;
    iao_freg_t   freg;
    logic [7:0]  w;
    logic        z;
    logic        z_wr;
    logic        pc_skip;
    logic        done;
    iao_phase_t  phase;
    int          num_errors;
    int          checks;
    iao_exec i_iao_exec (.i_core_clk(core_clk), .i_rst_n(rst_n), .i_instr(instr),
        .i_freg_rdata(rdata), .o_freg(freg), .o_w(w), .o_z(z), .o_z_wr(z_wr),
        .o_pc_skip(pc_skip), .o_done(done), .o_phase(phase));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic give_verdict();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic cmp(input logic [20:0] got, input logic [20:0] exp, input logic [20:0] msk);
        checks++;
        if (((got ^ exp) & msk) !== 21'h000000) begin
            num_errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // one full instruction slot; returns at the negedge of the next Q1
    task automatic exec(input logic [13:0] ins, input logic [7:0] rdv, input logic erd);
        int n;
        n = 0;
        while (phase !== IAO_Q1 && n < 8) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 8) begin
            num_errors++;
            give_verdict();
        end
        instr = ins;
        rdata = rdv;
        repeat (2) @(negedge core_clk);
        cmp({11'h000, phase, freg.rd, freg.addr}, {11'h000, IAO_Q3, erd, ins[6:0]},
            {11'h000, 2'b11, 1'b1, {7{erd}}});
        repeat (2) @(negedge core_clk);
    endtask
    task automatic post(input logic [20:0] exp, input logic [20:0] msk);
        cmp({w, z, z_wr, freg.wr, freg.wdata, pc_skip, done}, exp, msk);
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_inc();
        exec({OPC_INC_HI, DEST_W, 7'h15}, 8'hFF, 1'b1);
        post({8'h00, 1'b1, 1'b1, 1'b0, 8'h00, 1'b0, 1'b1}, NWD);
        exec({OPC_INC_HI, DEST_W, 7'h00}, 8'h41, 1'b1);
        post({8'h42, 1'b0, 1'b1, 1'b0, 8'h00, 1'b0, 1'b1}, NWD);
        exec({OPC_INC_HI, DEST_F, 7'h7F}, 8'h7F, 1'b1);
        post({8'h42, 1'b0, 1'b1, 1'b1, 8'h80, 1'b0, 1'b1}, ALL);
        cmp({14'h0000, freg.addr}, {14'h0000, 7'h7F}, ALL);
        $display("test inc finished");
    endtask
    task automatic t_skip();
        exec({OPC_INCSZ_HI, DEST_F, 7'h22}, 8'hFF, 1'b1);
        post({8'h42, 1'b0, 1'b0, 1'b1, 8'h00, 1'b1, 1'b1}, ALL);
        cmp({14'h0000, freg.addr}, {14'h0000, 7'h22}, ALL);
        // this slot must be swallowed: no read, no write, w kept
        exec({OPC_INC_HI, DEST_W, 7'h10}, 8'h05, 1'b0);
        post({8'h42, 1'b0, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0}, NDN);
        exec({OPC_INCSZ_HI, DEST_W, 7'h33}, 8'h10, 1'b1);
        post({8'h11, 1'b0, 1'b0, 1'b0, 8'h00, 1'b0, 1'b1}, NWD);
        // zero into w: w takes 00, flag left alone, next slot swallowed
        exec({OPC_INCSZ_HI, DEST_W, 7'h44}, 8'hFF, 1'h1);
        post({8'h00, 1'h0, 1'h0, 1'h0, 8'h00, 1'h1, 1'h1}, NWD);
        exec({OPC_IORL_HI, 8'h0F}, 8'h00, 1'h0);
        post({8'h00, 1'h0, 1'h0, 1'h0, 8'h00, 1'h0, 1'h0}, NDN);
        $display("test skip finished");
    endtask
    task automatic t_iorl();
        exec({OPC_INC_HI, DEST_W, 7'h05}, 8'h99, 1'b1);
        exec({OPC_IORL_HI, 8'h35}, 8'h00, 1'b0);
        post({8'hBF, 1'b0, 1'b1, 1'b0, 8'h00, 1'b0, 1'b1}, NWD);
        exec({OPC_INC_HI, DEST_W, 7'h05}, 8'hFF, 1'b1);
        exec({OPC_IORL_HI, 8'h80}, 8'hAA, 1'b0);
        post({8'h80, 1'b0, 1'b1, 1'b0, 8'h00, 1'b0, 1'b1}, NWD);
        // unknown opcode leaves everything alone
        exec(14'h0700, 8'h00, 1'b0);
        post({8'h80, 1'b0, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0}, NDN);
        $display("test iorl finished");
    endtask
    task automatic t_reset();
        @(negedge core_clk);
        rst_n = 1'h0;
        @(negedge core_clk);
        cmp({11'h000, phase, freg.rd, freg.addr},
            {11'h000, IAO_Q1, 1'h0, 7'h00}, ALL);
        post({8'h00, 1'h0, 1'h0, 1'h0, 8'h00, 1'h0, 1'h0}, ALL);
        repeat (2) @(negedge core_clk);
        rst_n = 1'h1;
        // w restarts at zero, so or-ing zero gives zero and sets the flag
        exec({OPC_IORL_HI, 8'h00}, 8'h00, 1'h0);
        post({8'h00, 1'h1, 1'h1, 1'h0, 8'h00, 1'h0, 1'h1}, NWD);
        $display("test reset finished");
    endtask
    // ----------------------------------------------------------------
    // clock, reset and sequence
    // ----------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        num_errors = 0;
        checks = 0;
        rst_n = 1'b0;
        instr = INSTR_NOP;
        rdata = 8'h00;
        repeat (10) @(negedge core_clk);
        rst_n = 1'b1;
        t_inc();
        t_skip();
        t_iorl();
        t_reset();
        give_verdict();
    end
endmodule
`default_nettype wire
